// >>> core/flash_command_sequencer.sv
// flash command sequencer with APB registers, timing and security gate
`include "flash_seq_defines.svh"
module flash_command_sequencer
  import flash_seq_pkg::*;
#(
  parameter logic [15:0] BYTE_CYCLES = `CYC_BYTE,
  parameter logic [15:0] BURST_CYCLES = `CYC_BURST,
  parameter logic [15:0] PAGE_CYCLES = `CYC_PAGE,
  parameter logic [15:0] MASS_CYCLES = `CYC_MASS,
  parameter logic [15:0] BLANK_CYCLES = `CYC_BLANK
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [16:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // nonvolatile stores
  input wire logic [63:0] NV_KEY,
  input wire logic [7:0] NV_PROT,
  input wire logic [7:0] NV_OPT,
  // source of the current access
  input wire logic BKGD_ACCESS,
  input wire logic SECURE_FETCH,
  // flash array
  output logic [15:0] FL_ADDR,
  output logic [7:0] FL_DATA,
  output logic [7:0] FL_CMD,
  output logic FL_START,
  output logic FL_HV,
  input wire logic FL_BLANK,
  // ram gate
  input wire logic RAM_SRC_BKGD,
  input wire logic RAM_SRC_NONSECURE,
  output logic RAM_BLOCK,
  output logic SECURE
);
  seq_t seq;
  exe_t ex;
  logic [7:0] div_reg;
  logic [7:0] working_option_reg;
  logic [7:0] working_protection_reg;
  logic [63:0] key_store;
  logic [31:0] key_lo;
  logic nv_loaded;
  logic unlocked;
  logic access_error_flag;
  logic blank_flag;
  logic pend;
  logic [15:0] lat_addr;
  logic [7:0] lat_data;
  logic [7:0] command_code_reg;
  logic [15:0] cur_addr;
  logic [7:0] cur_cmd;
  logic hv_keep;
  logic timer_start;
  logic [15:0] timer_cycles;
  logic timer_done;
  logic is_array;
  logic mapped;
  logic wr;
  logic wr_array;
  logic wr_div;
  logic wr_stat;
  logic wr_cmd;
  logic launch;
  logic abort;
  logic seq_err;
  logic take;
  logic cmd_complete_flag;
  logic [7:0] flash_status_reg;
  logic [31:0] rd_mux;

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic reg_hit(input logic [16:0] a, input logic [7:0] off);
    reg_hit = (a[16:8] == 9'h000) && (a[7:0] == off);
  endfunction : reg_hit

  function automatic logic code_valid(input logic [7:0] c);
    code_valid = (c == `CMD_BLANK) || (c == `CMD_PROG) || (c == `CMD_BURST) ||
      (c == `CMD_PAGE) || (c == `CMD_MASS);
  endfunction : code_valid

  function automatic logic [15:0] cmd_cycles(input logic [7:0] c, input logic fast);
    if (c == `CMD_PROG) begin
      cmd_cycles = BYTE_CYCLES;
    end else if (c == `CMD_BURST) begin
      cmd_cycles = fast ? BURST_CYCLES : BYTE_CYCLES;
    end else if (c == `CMD_PAGE) begin
      cmd_cycles = PAGE_CYCLES;
    end else if (c == `CMD_MASS) begin
      cmd_cycles = MASS_CYCLES;
    end else begin
      cmd_cycles = BLANK_CYCLES;
    end
  endfunction : cmd_cycles

  assign is_array = PADDR[`ARRAY_SEL_BIT];
  assign mapped = is_array || reg_hit(PADDR, `REG_DIV) || reg_hit(PADDR, `REG_OPT) ||
    reg_hit(PADDR, `REG_PROT) || reg_hit(PADDR, `REG_STAT) || reg_hit(PADDR, `REG_CMD) ||
    reg_hit(PADDR, `REG_KEYLO) || reg_hit(PADDR, `REG_KEYHI) || reg_hit(PADDR, `REG_SEC);
  assign wr = PSEL && PENABLE && PWRITE && PREADY;
  assign wr_array = wr && is_array;
  assign wr_div = wr && reg_hit(PADDR, `REG_DIV);
  assign wr_stat = wr && reg_hit(PADDR, `REG_STAT);
  assign wr_cmd = wr && reg_hit(PADDR, `REG_CMD);

  assign cmd_complete_flag = !pend && (ex == EX_IDLE);
  assign flash_status_reg = {!pend, cmd_complete_flag, 1'b0, access_error_flag,
    1'b0, blank_flag, 2'b00};

  // ****************************************
  // sequence checks
  // ****************************************
  assign launch = wr_stat && PWDATA[`STAT_CBE] && (seq == SEQ_CMD) &&
    !access_error_flag;
  assign abort = wr_stat && !PWDATA[`STAT_CBE] && (seq != SEQ_IDLE);
  always_comb begin
    seq_err = 1'b0;
    if (abort) begin
      seq_err = 1'b1;
    end else if (access_error_flag) begin
      seq_err = 1'b0;
    end else if (wr_array) begin
      seq_err = !div_reg[`DIV_LOADED] || pend || (seq != SEQ_IDLE);
    end else if (wr_cmd) begin
      seq_err = (seq != SEQ_ADDR) || !code_valid(PWDATA[7:0]) ||
        (BKGD_ACCESS && SECURE && (PWDATA[7:0] != `CMD_BLANK) &&
        (PWDATA[7:0] != `CMD_MASS));
    end else if (wr_div) begin
      seq_err = (seq != SEQ_IDLE);
    end else if (wr_stat && PWDATA[`STAT_CBE]) begin
      seq_err = (seq == SEQ_ADDR);
    end
  end

  // ****************************************
  // apb answer: one wait state, registered read data
  // ****************************************
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (reg_hit(PADDR, `REG_DIV)) begin
      rd_mux = {24'h00_0000, div_reg};
    end else if (reg_hit(PADDR, `REG_OPT)) begin
      rd_mux = {24'h00_0000, working_option_reg};
    end else if (reg_hit(PADDR, `REG_PROT)) begin
      rd_mux = {24'h00_0000, working_protection_reg};
    end else if (reg_hit(PADDR, `REG_STAT)) begin
      rd_mux = {24'h00_0000, flash_status_reg};
    end else if (reg_hit(PADDR, `REG_CMD)) begin
      rd_mux = {24'h00_0000, command_code_reg};
    end else if (reg_hit(PADDR, `REG_SEC)) begin
      rd_mux = {31'h0000_0000, SECURE};
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && PENABLE && !PREADY;
      if (PSEL && PENABLE && !PREADY) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : rd_mux;
        PSLVERR <= !mapped;
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

  // ****************************************
  // clock divider register, written once
  // ****************************************
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      div_reg <= 8'h00;
    end else if (wr_div && !div_reg[`DIV_LOADED] && !access_error_flag &&
      (seq == SEQ_IDLE)) begin
      div_reg <= {1'b1, PWDATA[6:0]};
    end
  end

  // ****************************************
  // nonvolatile copy after reset release
  // ****************************************
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      nv_loaded <= 1'b0;
      working_option_reg <= `OPT_RESET;
      working_protection_reg <= `PROT_RESET;
      key_store <= 64'h0000_0000_0000_0000;
    end else if (!nv_loaded) begin
      nv_loaded <= 1'b1;
      working_option_reg <= NV_OPT;
      working_protection_reg <= NV_PROT;
      key_store <= NV_KEY;
    end
  end

  // ****************************************
  // backdoor key and security state
  // ****************************************
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      key_lo <= 32'h0000_0000;
      unlocked <= 1'b0;
    end else if (working_option_reg[`OPT_KEY_ENABLE] && SECURE_FETCH &&
      !BKGD_ACCESS) begin
      if (wr && reg_hit(PADDR, `REG_KEYLO)) begin
        key_lo <= PWDATA;
      end else if (wr && reg_hit(PADDR, `REG_KEYHI) && ({PWDATA, key_lo} == key_store)) begin
        unlocked <= 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      SECURE <= 1'b1;
      RAM_BLOCK <= 1'b0;
    end else begin
      SECURE <= (working_option_reg[1:0] != `SEC_OPEN) && !unlocked;
      RAM_BLOCK <= SECURE && (RAM_SRC_BKGD || RAM_SRC_NONSECURE);
    end
  end

  // ****************************************
  // command sequence and latches
  // ****************************************
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      seq <= SEQ_IDLE;
      lat_addr <= 16'h0000;
      lat_data <= 8'h00;
      command_code_reg <= 8'h00;
    end else if (seq_err || launch) begin
      seq <= SEQ_IDLE;
    end else if (wr_array && !access_error_flag) begin
      seq <= SEQ_ADDR;
      lat_addr <= PADDR[15:0];
      lat_data <= PWDATA[7:0];
    end else if (wr_cmd && !access_error_flag) begin
      seq <= SEQ_CMD;
      command_code_reg <= PWDATA[7:0];
    end
  end

  // access error: set wins over the clear
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      access_error_flag <= 1'b0;
    end else if (seq_err) begin
      access_error_flag <= 1'b1;
    end else if (wr_stat && PWDATA[`STAT_ACCERR]) begin
      access_error_flag <= 1'b0;
    end
  end

  // ****************************************
  // command buffer
  // ****************************************
  assign take = pend && (ex == EX_IDLE);
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      pend <= 1'b0;
    end else if (launch) begin
      pend <= 1'b1;
    end else if (take) begin
      pend <= 1'b0;
    end
  end

  // ****************************************
  // executor
  // ****************************************
  assign timer_start = take;
  assign timer_cycles = cmd_cycles(command_code_reg, hv_keep);
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      ex <= EX_IDLE;
      cur_addr <= 16'h0000;
      cur_cmd <= 8'h00;
      FL_ADDR <= 16'h0000;
      FL_DATA <= 8'h00;
      FL_CMD <= 8'h00;
      FL_START <= 1'b0;
    end else begin
      FL_START <= take;
      case (ex)
        EX_IDLE: begin
          if (take) begin
            ex <= EX_RUN;
            cur_addr <= lat_addr;
            cur_cmd <= command_code_reg;
            FL_ADDR <= lat_addr;
            FL_DATA <= lat_data;
            FL_CMD <= command_code_reg;
          end
        end
        EX_RUN: begin
          if (timer_done) begin
            ex <= EX_IDLE;
          end
        end
        default: begin
          ex <= EX_IDLE;
        end
      endcase
    end
  end

  // burst keeps high voltage on while any command is queued; only the next byte on the same row takes the short count
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      hv_keep <= 1'b0;
      FL_HV <= 1'b0;
    end else begin
      if (timer_done) begin
        hv_keep <= (cur_cmd == `CMD_BURST) && pend && (command_code_reg == `CMD_BURST) &&
          (lat_addr == cur_addr + 16'h0001) &&
          (lat_addr[`ROW_BITS-1:0] != 6'h00);
      end else if (take) begin
        hv_keep <= 1'b0;
      end
      FL_HV <= (ex == EX_RUN && !timer_done) || take ||
        (timer_done && (cur_cmd == `CMD_BURST) && pend);
    end
  end

  // blank check result
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      blank_flag <= 1'b0;
    end else if (timer_done && (cur_cmd == `CMD_BLANK)) begin
      blank_flag <= FL_BLANK;
    end else if (launch) begin
      blank_flag <= 1'b0;
    end
  end

  flash_pulse_timer u_timer (
    .clk(MCLK),
    .reset(RESET),
    .prescale(div_reg[`DIV_PRE]),
    .div(div_reg[5:0]),
    .start(timer_start),
    .cycles(timer_cycles),
    .done(timer_done)
  );
endmodule : flash_command_sequencer

// >>> common/flash_seq_defines.svh
// constants for the flash command sequencer: offsets, fields, codes, counts
//
// What this block does
// - divider register accepts one write per reset
// - divider write ignored while access error set
// - pulses timed in whole timing-clock periods
// - byte 9, burst 4, page 4000, mass 20000
// - array write latches address and data first
// - page erase any page address; data ignored
// - smallest erase unit is one 512-byte page
// - codes 0x05 blank, 0x20 program, 0x25 burst
// - codes 0x40 page erase, 0x41 mass erase
// - writing one to buffer-empty launches command
// - writing zero to buffer-empty aborts, sets error
// - command complete flag reports finished command
// - reset copies protection and option stores
// - key enable gates backdoor key unsecuring
// - key accepted only from secure code, not debug
// - only security pattern 1:0 means unsecured
// - secured: block debug and non-secure RAM access
// - access error cleared by one; blocks commands
// - array write with buffer not empty is error
// - invalid command code sets access error
`ifndef FLASH_SEQ_DEFINES_SVH
`define FLASH_SEQ_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define REG_DIV 8'h00
`define REG_OPT 8'h04
`define REG_PROT 8'h08
`define REG_STAT 8'h0C
`define REG_CMD 8'h10
`define REG_KEYLO 8'h14
`define REG_KEYHI 8'h18
`define REG_SEC 8'h1C
`define ARRAY_SEL_BIT 16

// nonvolatile store locations inside the array
`define NV_KEY_ADDR 16'hFFB0
`define NV_PROT_ADDR 16'hFFBD
`define NV_OPT_ADDR 16'hFFBF

// ****************************************
// fields
// ****************************************
`define DIV_LOADED 7
`define DIV_PRE 6
`define STAT_CBE 7
`define STAT_CCF 6
`define STAT_ACCERR 4
`define STAT_BLANK 2
`define OPT_KEY_ENABLE 7
`define SEC_OPEN 2'h2
`define OPT_RESET 8'h00
`define PROT_RESET 8'hFF
`define ROW_BITS 6
`define PRESCALE_LAST 3'h7

// ****************************************
// command codes and durations in timing-clock cycles
// ****************************************
`define CMD_BLANK 8'h05
`define CMD_PROG 8'h20
`define CMD_BURST 8'h25
`define CMD_PAGE 8'h40
`define CMD_MASS 8'h41
`define CYC_BYTE 16'h0009
`define CYC_BURST 16'h0004
`define CYC_PAGE 16'h0FA0
`define CYC_MASS 16'h4E20
`define CYC_BLANK 16'h0004

`endif

// >>> common/flash_seq_pkg.sv
// types shared by the flash command sequencer
package flash_seq_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_ADDR = 3'b010,
    SEQ_CMD = 3'b100
  } seq_t;
  typedef enum logic [1:0] {
    EX_IDLE = 2'b01,
    EX_RUN = 2'b10
  } exe_t;
endpackage : flash_seq_pkg

// >>> core/flash_pulse_timer.sv
// timing-clock divider and whole-period pulse counter
`include "flash_seq_defines.svh"
module flash_pulse_timer (
  input wire logic clk,
  input wire logic reset,
  input wire logic prescale,
  input wire logic [5:0] div,
  input wire logic start,
  input wire logic [15:0] cycles,
  output logic done
);
  logic [2:0] pre_cnt;
  logic [5:0] div_cnt;
  logic [15:0] left;
  logic running;
  logic pre_tick;
  logic timing_tick;

  assign pre_tick = !prescale || (pre_cnt == `PRESCALE_LAST);
  assign timing_tick = pre_tick && (div_cnt == div);

  // ****************************************
  // divider, restarted on start so periods are whole
  // ****************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pre_cnt <= 3'h0;
      div_cnt <= 6'h00;
    end else if (start) begin
      pre_cnt <= 3'h0;
      div_cnt <= 6'h00;
    end else begin
      pre_cnt <= pre_tick ? 3'h0 : pre_cnt + 3'h1;
      if (pre_tick) begin
        div_cnt <= timing_tick ? 6'h00 : div_cnt + 6'h01;
      end
    end
  end

  // ****************************************
  // period counter
  // ****************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      left <= 16'h0000;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        left <= cycles;
        running <= 1'b1;
      end else if (running && timing_tick) begin
        left <= left - 16'h0001;
        if (left == 16'h0001) begin
          running <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule : flash_pulse_timer

// >>> verification/flash_command_sequencer_properties.sv
// port-level checks for the flash command sequencer
`include "flash_seq_defines.svh"
module flash_command_sequencer_properties (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [16:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  // stores and access source
  input wire logic [7:0] NV_PROT,
  input wire logic [7:0] NV_OPT,
  input wire logic BKGD_ACCESS,
  // array and ram gate
  input wire logic [7:0] FL_CMD,
  input wire logic FL_START,
  input wire logic RAM_SRC_BKGD,
  input wire logic RAM_SRC_NONSECURE,
  input wire logic RAM_BLOCK,
  input wire logic SECURE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  logic acc;
  logic launch;
  assign acc = PSEL && PENABLE && PREADY;
  assign launch = acc && PWRITE && PADDR == {9'h000, `REG_STAT} && PWDATA[`STAT_CBE];
  // a launch write seen since the last start; a queued command may start much later
  logic armed;
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      armed <= 1'b0;
    end else if (launch) begin
      armed <= 1'b1;
    end else if (FL_START) begin
      armed <= 1'b0;
    end
  end
  chk_opt_copy: assert property (
    acc && !PWRITE && PADDR == {9'h000, `REG_OPT} |-> PRDATA == {24'h00_0000, NV_OPT})
    else $error("working option differs from store");
  chk_prot_copy: assert property (
    acc && !PWRITE && PADDR == {9'h000, `REG_PROT} |-> PRDATA == {24'h00_0000, NV_PROT})
    else $error("working protection differs from store");
  chk_secure_release: assert property (
    $fell(SECURE) |-> NV_OPT[1:0] == `SEC_OPEN || NV_OPT[`OPT_KEY_ENABLE])
    else $error("security dropped without open pattern or key");
  chk_debug_key: assert property (
    acc && PWRITE && PADDR == {9'h000, `REG_KEYHI} && BKGD_ACCESS && SECURE |=> SECURE [*3])
    else $error("debug key entry dropped security");
  chk_ram_gate: assert property (
    1'b1 |=> RAM_BLOCK == $past(SECURE && (RAM_SRC_BKGD || RAM_SRC_NONSECURE)))
    else $error("ram gate wrong");
  chk_start_pulse: assert property (
    FL_START |=> !FL_START)
    else $error("start longer than one cycle");
  chk_start_cause: assert property (
    $rose(FL_START) |-> armed)
    else $error("start without launch write");
  chk_start_code: assert property (
    FL_START |-> FL_CMD inside {`CMD_BLANK, `CMD_PROG, `CMD_BURST, `CMD_PAGE, `CMD_MASS})
    else $error("start with undefined code");
endmodule : flash_command_sequencer_properties

bind flash_command_sequencer flash_command_sequencer_properties chk (
  .MCLK(MCLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .NV_PROT(NV_PROT),
  .NV_OPT(NV_OPT), .BKGD_ACCESS(BKGD_ACCESS), .FL_CMD(FL_CMD), .FL_START(FL_START),
  .RAM_SRC_BKGD(RAM_SRC_BKGD), .RAM_SRC_NONSECURE(RAM_SRC_NONSECURE),
  .RAM_BLOCK(RAM_BLOCK), .SECURE(SECURE)
);

// >>> verification/flash_command_sequencer_tb_top.sv
// self-checking bench for the flash command sequencer
`include "flash_seq_defines.svh"
module flash_command_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // signals and design
  // ****************************************
  localparam logic [15:0] MASS = 16'h0010;
  logic MCLK = 1'b0;
  logic RESET = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [16:0] PADDR = 17'h0_0000;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] PRDATA;
  logic [31:0] q;
  logic PREADY, PSLVERR, e, FL_START, FL_HV, RAM_BLOCK, SECURE;
  logic [63:0] NV_KEY = 64'h1357_9BDF_2468_ACE0;
  logic [7:0] NV_PROT = 8'hF8;
  logic [7:0] NV_OPT = 8'h02;
  logic BKGD_ACCESS = 1'b0;
  logic SECURE_FETCH = 1'b0;
  logic FL_BLANK = 1'b0;
  logic RAM_SRC_BKGD = 1'b0;
  logic RAM_SRC_NONSECURE = 1'b0;
  logic [15:0] FL_ADDR;
  logic [7:0] FL_DATA;
  logic [7:0] FL_CMD;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  int t0 = 0;
  int nst = 0;

  flash_command_sequencer #(.MASS_CYCLES(MASS)) DUT (
    .MCLK(MCLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .NV_KEY(NV_KEY), .NV_PROT(NV_PROT), .NV_OPT(NV_OPT), .BKGD_ACCESS(BKGD_ACCESS),
    .SECURE_FETCH(SECURE_FETCH), .FL_ADDR(FL_ADDR), .FL_DATA(FL_DATA), .FL_CMD(FL_CMD),
    .FL_START(FL_START), .FL_HV(FL_HV), .FL_BLANK(FL_BLANK), .RAM_SRC_BKGD(RAM_SRC_BKGD),
    .RAM_SRC_NONSECURE(RAM_SRC_NONSECURE), .RAM_BLOCK(RAM_BLOCK), .SECURE(SECURE)
  );

  initial begin
    forever #5 MCLK = ~MCLK;
  end

  // cycle count and start capture
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (FL_START === 1'b1) begin
      t0 <= cyc;
      nst <= nst + 1;
    end
  end

  // ****************************************
  // common tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic xfer(input logic w, input logic [16:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, {9'h000, a}, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, {9'h000, a}, 32'h0000_0000);
  endtask : rd

  task automatic arr(input logic [15:0] a);
    xfer(1'b1, {1'b1, a}, 32'h0000_005A);
  endtask : arr

  task automatic rst(input logic [7:0] opt);
    RESET <= 1'b1;
    NV_OPT <= opt;
    repeat (3) @(posedge MCLK);
    RESET <= 1'b0;
    repeat (3) @(posedge MCLK);
  endtask : rst

  // reads the error flag, clears it by writing one, reads it again
  task automatic err_seen;
    rd(`REG_STAT);
    check(q[`STAT_ACCERR], 1'b1);
    wr(`REG_STAT, 32'h0000_0090);
    rd(`REG_STAT);
    check(q[`STAT_ACCERR], 1'b0);
  endtask : err_seen

  task automatic key(input logic [63:0] k);
    wr(`REG_KEYLO, k[31:0]);
    wr(`REG_KEYHI, k[63:32]);
    repeat (2) @(posedge MCLK);
  endtask : key

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rd(`REG_OPT);
    check(q, {24'h00_0000, NV_OPT});
    rd(`REG_PROT);
    check(q, {24'h00_0000, NV_PROT});
    check(SECURE, 1'b0);
    rd(8'h40);
    check(e, 1'b1);
    $display("reset test done");
  endtask : t_reset

  task automatic t_div;
    arr(16'h1000);
    err_seen();
    arr(16'h1000);
    wr(`REG_DIV, 32'h0000_0001);
    rd(`REG_DIV);
    check(q[7:0], 8'h00);
    err_seen();
    wr(`REG_DIV, 32'h0000_0001);
    wr(`REG_DIV, 32'h0000_0007);
    rd(`REG_DIV);
    check(q[7:0], 8'h81);
    $display("divider test done");
  endtask : t_div

  task automatic t_cmds;
    logic [7:0] codes [5] = '{`CMD_PROG, `CMD_BURST, `CMD_PAGE, `CMD_MASS, `CMD_BLANK};
    logic [15:0] lens [5] = '{`CYC_BYTE, `CYC_BYTE, `CYC_PAGE, MASS, `CYC_BLANK};
    int s;
    int lim;
    int n;
    FL_BLANK <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      s = nst;
      n = int'(lens[i]);
      arr(16'h1003 + 16'(i) * 16'h0201);
      wr(`REG_CMD, {24'h00_0000, codes[i]});
      wr(`REG_STAT, 32'h0000_0080);
      rd(`REG_STAT);
      check(q[`STAT_CBE], 1'b1);
      check(FL_HV, 1'b1);
      lim = cyc + 2 * n + 100;
      do rd(`REG_STAT); while (q[`STAT_CCF] !== 1'b1 && cyc < lim);
      check(q[`STAT_CCF], 1'b1);
      check(nst - s, 1);
      check(FL_CMD, codes[i]);
      check(FL_ADDR, 16'h1003 + 16'(i) * 16'h0201);
      check(FL_DATA, 8'h5A);
      check(FL_HV, 1'b0);
      check(cyc - t0 >= 2 * n - 2 && cyc - t0 <= 2 * n + 12, 1'b1);
      if (codes[i] == `CMD_BLANK) check(q[`STAT_BLANK], 1'b1);
    end
    $display("command test done");
  endtask : t_cmds

  // next burst byte queued on the same row while the first runs takes the short count
  task automatic t_burst;
    int s;
    int lim;
    s = nst;
    for (int i = 0; i < 2; i++) begin
      arr(16'h3010 + 16'(i));
      wr(`REG_CMD, {24'h00_0000, `CMD_BURST});
      wr(`REG_STAT, 32'h0000_0080);
    end
    lim = cyc + 200;
    do rd(`REG_STAT); while (q[`STAT_CCF] !== 1'b1 && cyc < lim);
    check(q[`STAT_CCF], 1'b1);
    check(nst - s, 2);
    check(FL_ADDR, 16'h3011);
    check(cyc - t0 >= 2 * `CYC_BURST && cyc - t0 <= 2 * `CYC_BURST + 12, 1'b1);
    $display("burst test done");
  endtask : t_burst

  task automatic t_abort;
    int s;
    s = nst;
    arr(16'h2000);
    wr(`REG_STAT, 32'h0000_0000);
    wr(`REG_CMD, {24'h00_0000, `CMD_PROG});
    wr(`REG_STAT, 32'h0000_0080);
    repeat (4) @(posedge MCLK);
    check(nst - s, 0);
    err_seen();
    arr(16'h2000);
    wr(`REG_CMD, 32'h0000_0033);
    err_seen();
    arr(16'h2000);
    arr(16'h2001);
    err_seen();
    $display("abort test done");
  endtask : t_abort

  task automatic t_sec;
    logic [7:0] opts [3] = '{8'h01, 8'h03, 8'h80};
    for (int i = 0; i < 3; i++) begin
      rst(opts[i]);
      check(SECURE, opts[i][1:0] != `SEC_OPEN);
    end
    RAM_SRC_NONSECURE <= 1'b1;
    BKGD_ACCESS <= 1'b1;
    SECURE_FETCH <= 1'b1;
    key(NV_KEY);
    check(RAM_BLOCK, 1'b1);
    check(SECURE, 1'b1);
    rst(8'h80);
    BKGD_ACCESS <= 1'b0;
    key(NV_KEY);
    check(SECURE, 1'b0);
    check(RAM_BLOCK, 1'b0);
    rst(8'h00);
    key(NV_KEY);
    check(SECURE, 1'b1);
    $display("security test done");
  endtask : t_sec

  initial begin
    #200us;
    fails++;
    complete_run();
  end

  initial begin
    rst(8'h02);
    t_reset();
    t_div();
    t_cmds();
    t_burst();
    t_abort();
    t_sec();
    complete_run();
  end
endmodule : flash_command_sequencer_tb_top
